// >>> rtl/dacr_pkg.sv
// shared constants and types for the dual converter readout control
package dacr_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_MIN_NS = 15;
  localparam int STROBE_MIN_CYC_I =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] STROBE_MIN_CYC = 2'(STROBE_MIN_CYC_I);
  // frame layout
  localparam int RESULT_W = 16;
  localparam int FRAME_BITS = 20;
  localparam int DUAL_BITS = 40;
  localparam int FLAG_CH_POS = 19;
  localparam int FLAG_SIDE_POS = 18;
  localparam int RES_MSB_POS = 17;
  localparam int RES_LSB_POS = 2;
  localparam logic [1:0] FRAME_TAIL = 2'h0;
  // cycle counts on the external clock
  localparam logic [4:0] CONV_CYCLES = 5'h14;
  localparam logic [5:0] FRAME_XFER = 6'h14;
  localparam logic [5:0] DUAL_XFER = 6'h28;
  localparam logic [1:0] READ_VALID_EDGE = 2'h3;
  // synchroniser depth and pin group width
  localparam int SYNC_STAGES = 3;
  localparam int PIN_W = 7;
  // reset values
  localparam logic BUSY_RST = 1'b0;
  localparam logic B_OE_RST = 1'b1;
  localparam logic CH_RST = 1'b0;
  // conversion sequencer
  typedef enum logic [1:0] {
    DACR_IDLE = 2'b00,
    DACR_PEND = 2'b01,
    DACR_ARM = 2'b10,
    DACR_RUN = 2'b11
  } dacr_conv_state_t;
endpackage : dacr_pkg

// >>> rtl/dacr_shift_if.sv
// carrier between the sequencer and one serial frame shifter
interface dacr_shift_if #(parameter int W = 20);
  logic load;
  logic shift;
  logic [W-1:0] word;
  logic ser_bit;
  modport ctrl (output load, output shift, output word, input ser_bit);
  modport unit (input load, input shift, input word, output ser_bit);
endinterface : dacr_shift_if

// >>> rtl/dacr_pin_sync.sv
// three-stage pin synchroniser with agreement filter
module dacr_pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_lvl
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;

  if (W < 1) $error("pin group width must be at least one");

  // first stage feeds only the second one
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      lvl_ff <= '0;
    else
      lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
  end

  assign pin_lvl = lvl_ff;
endmodule : dacr_pin_sync

// >>> rtl/dacr_frame_shift.sv
// msb-first frame shifter, zero fill behind the frame
module dacr_frame_shift #(
  parameter int W = 20
) (
  input wire logic ref_clk,
  input wire logic resetn,
  dacr_shift_if.unit sh
);
  logic [W-1:0] sreg_ff;

  if (W < 2) $error("shifter width must be at least two");

  // load wins over shift; the line idles low after the frame
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      sreg_ff <= '0;
    else if (sh.load)
      sreg_ff <= sh.word;
    else if (sh.shift)
      sreg_ff <= {sreg_ff[W-2:0], 1'b0};
  end

  assign sh.ser_bit = sreg_ff[W-1];
endmodule : dacr_frame_shift

// >>> rtl/dacr_top.sv
// conversion sequencing and serial readout of the dual converter

// Summary of operation
// [R1] mode one: pair member from select line, data on both outputs
// [R2] host holds the start strobe high at least 15 ns
// [R3] host avoids raising the strobe near a falling clock edge
// [R4] a conversion takes twenty external clock cycles
// [R5] strobe puts sampler in hold at once; busy high whole conversion
// [R6] falling edge of cycle one latches pair member for next conversion
// [R7] host holds chip select low for the strobes to act
// [R8] frame: member flag, side flag, sixteen result bits, two zeros
// [R9] mode one sends both leading flags as zero
// [R10] mode two: both results on output a over forty cycles, b floats
// [R11] with output select high the second strobe is ignored
// [R12] mode three alternates pair members, ignores select, both outputs
// [R13] mode four alternates, output a only, b floats after a conversion
// [R14] data valid from third rising clock edge after read strobe rises
// [R15] strobe before a falling edge starts conversion at next rising edge
// [R16] host may tie start and read strobes together
// [R17] output bits change after rising edges, stable at falling edges
module dacr_top #(
  parameter int RESULT_W = dacr_pkg::RESULT_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ext_clk,
  input wire logic conversion_start_strobe,
  input wire logic read_strobe,
  input wire logic chip_select_n,
  input wire logic channel_count_select,
  input wire logic output_port_select,
  input wire logic pair_member_select,
  input wire logic [RESULT_W-1:0] result_a_in,
  input wire logic [RESULT_W-1:0] result_b_in,
  output logic busy,
  output logic sample_hold,
  output logic serial_a,
  output logic serial_b,
  output logic serial_b_oe
);
  if (RESULT_W != dacr_pkg::RESULT_W)
    $error("frame layout serves sixteen-bit results only");

  logic [dacr_pkg::PIN_W-1:0] pins_lvl;
  logic clk_lvl;
  logic stb_lvl;
  logic rd_lvl;
  logic csn_lvl;
  logic alt_lvl;
  logic dual_lvl;
  logic a0_lvl;
  logic clk_prev_ff;
  logic rise;
  logic fall;
  logic [1:0] stb_cnt_ff;
  logic stb_take;
  logic ignore;
  dacr_pkg::dacr_conv_state_t state_ff;
  logic [4:0] conv_cnt_ff;
  logic busy_ff;
  logic hold_ff;
  logic conv_end;
  logic next_ch_ff;
  logic cur_ch_ff;
  logic res_ch_ff;
  logic [RESULT_W-1:0] res_a_ff;
  logic [RESULT_W-1:0] res_b_ff;
  logic b_oe_ff;
  logic rd_prev_ff;
  logic rd_rise;
  logic rd_arm_ff;
  logic [1:0] rd_cnt_ff;
  logic load;
  logic xfer_act_ff;
  logic xfer_dual_ff;
  logic [5:0] xfer_cnt_ff;
  logic [dacr_pkg::FRAME_BITS-1:0] frame_a;
  logic [dacr_pkg::FRAME_BITS-1:0] frame_b;

  dacr_shift_if #(.W(dacr_pkg::DUAL_BITS)) sa_if ();
  dacr_shift_if #(.W(dacr_pkg::FRAME_BITS)) sb_if ();

  // every host pin crosses into ref_clk here
  dacr_pin_sync #(.W(dacr_pkg::PIN_W)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in({ext_clk, conversion_start_strobe, read_strobe, chip_select_n,
             channel_count_select, output_port_select,
             pair_member_select}),
    .pin_lvl(pins_lvl)
  );

  assign {clk_lvl, stb_lvl, rd_lvl, csn_lvl, alt_lvl, dual_lvl, a0_lvl} =
    pins_lvl;

  // external clock edges seen in ref_clk
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      clk_prev_ff <= 1'b0;
    else
      clk_prev_ff <= clk_lvl;
  end

  assign rise = clk_lvl & ~clk_prev_ff;
  assign fall = ~clk_lvl & clk_prev_ff;

  // strobe must stay high the minimum time with chip select low
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      stb_cnt_ff <= 2'h0;
    else if (!stb_lvl || csn_lvl)
      stb_cnt_ff <= 2'h0;
    else if (stb_cnt_ff != dacr_pkg::STROBE_MIN_CYC)
      stb_cnt_ff <= stb_cnt_ff + 2'h1;
  end

  // one pulse per qualified strobe; a short pulse is dropped
  assign stb_take = stb_lvl && !csn_lvl &&
    (stb_cnt_ff == dacr_pkg::STROBE_MIN_CYC - 2'h1); // R2 R7

  // dual output holds off strobes until its transfer is done
  assign ignore = dual_lvl && xfer_act_ff; // R11

  assign conv_end = (state_ff == dacr_pkg::DACR_RUN) && rise &&
    (conv_cnt_ff == dacr_pkg::CONV_CYCLES);

  // conversion sequencer: strobe, falling edge, rising edge, run
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_ff <= dacr_pkg::DACR_IDLE;
      conv_cnt_ff <= 5'h0;
    end
    else
    begin
      case (state_ff)
        dacr_pkg::DACR_IDLE:
          if (stb_take && !ignore)
            state_ff <= dacr_pkg::DACR_PEND;
        dacr_pkg::DACR_PEND:
          if (fall)
            state_ff <= dacr_pkg::DACR_ARM; // R15
        dacr_pkg::DACR_ARM:
          if (rise)
          begin
            state_ff <= dacr_pkg::DACR_RUN; // R15
            conv_cnt_ff <= 5'h1;
          end
        dacr_pkg::DACR_RUN:
          if (conv_end)
          begin
            state_ff <= dacr_pkg::DACR_IDLE; // R4
            conv_cnt_ff <= 5'h0;
          end
          else if (rise)
            conv_cnt_ff <= conv_cnt_ff + 5'h1; // R4
        default:
          state_ff <= dacr_pkg::DACR_IDLE;
      endcase
    end
  end

  // hold and busy rise with the strobe, without waiting for a clock edge
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      busy_ff <= dacr_pkg::BUSY_RST;
      hold_ff <= dacr_pkg::BUSY_RST;
    end
    else if (state_ff == dacr_pkg::DACR_IDLE && stb_take && !ignore)
    begin
      busy_ff <= 1'b1; // R5
      hold_ff <= 1'b1; // R5
    end
    else if (conv_end)
    begin
      busy_ff <= 1'b0; // R5
      hold_ff <= 1'b0;
    end
  end

  // pair member: latched in cycle one, or alternating in auto mode
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      next_ch_ff <= dacr_pkg::CH_RST;
      cur_ch_ff <= dacr_pkg::CH_RST;
    end
    else
    begin
      if (state_ff == dacr_pkg::DACR_RUN && fall && conv_cnt_ff == 5'h1)
        next_ch_ff <= a0_lvl; // R6
      if (state_ff == dacr_pkg::DACR_ARM && rise)
        cur_ch_ff <= alt_lvl ? ~cur_ch_ff : next_ch_ff; // R1 R12 R13
    end
  end

  // results taken at the end of the conversion, sent on the next read
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      res_a_ff <= '0;
      res_b_ff <= '0;
      res_ch_ff <= dacr_pkg::CH_RST;
    end
    else if (conv_end)
    begin
      res_a_ff <= result_a_in;
      res_b_ff <= result_b_in;
      res_ch_ff <= cur_ch_ff;
    end
  end

  // output b floats only after a conversion completes in dual mode
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      b_oe_ff <= dacr_pkg::B_OE_RST;
    else if (!dual_lvl)
      b_oe_ff <= 1'b1; // R1 R12
    else if (conv_end)
      b_oe_ff <= 1'b0; // R10 R13
  end

  // read strobe edge, qualified by chip select
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rd_prev_ff <= 1'b0;
    else
      rd_prev_ff <= rd_lvl && !csn_lvl;
  end

  assign rd_rise = rd_lvl && !csn_lvl && !rd_prev_ff;

  // count rising clock edges after the read strobe
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      rd_arm_ff <= 1'b0;
      rd_cnt_ff <= 2'h0;
    end
    else if (rd_rise && !ignore)
    begin
      rd_arm_ff <= 1'b1;
      rd_cnt_ff <= 2'h0;
    end
    else if (load)
      rd_arm_ff <= 1'b0;
    else if (rd_arm_ff && rise)
      rd_cnt_ff <= rd_cnt_ff + 2'h1;
  end

  assign load = rd_arm_ff && rise &&
    (rd_cnt_ff == dacr_pkg::READ_VALID_EDGE - 2'h1); // R14

  // flags: member flag in auto modes, side flag in dual mode
  assign frame_a = {alt_lvl & res_ch_ff, 1'b0, res_a_ff,
                    dacr_pkg::FRAME_TAIL}; // R8 R9
  assign frame_b = {alt_lvl & res_ch_ff, dual_lvl, res_b_ff,
                    dacr_pkg::FRAME_TAIL}; // R8 R9 R10

  // transfer length: one frame, or both frames in turn on output a
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      xfer_act_ff <= 1'b0;
      xfer_dual_ff <= 1'b0;
      xfer_cnt_ff <= 6'h0;
    end
    else if (load)
    begin
      xfer_act_ff <= 1'b1;
      xfer_dual_ff <= dual_lvl;
      xfer_cnt_ff <= 6'h1;
    end
    else if (xfer_act_ff && rise)
    begin
      if (xfer_cnt_ff == (xfer_dual_ff ? dacr_pkg::DUAL_XFER
                                       : dacr_pkg::FRAME_XFER))
        xfer_act_ff <= 1'b0; // R10
      xfer_cnt_ff <= xfer_cnt_ff + 6'h1;
    end
  end

  // shifters move right after a rising edge; host samples on falling
  assign sa_if.load = load;
  assign sa_if.shift = xfer_act_ff && rise && !load; // R17
  assign sa_if.word = dual_lvl ? {frame_a, frame_b}
                               : {frame_a, {dacr_pkg::FRAME_BITS{1'b0}}};
  assign sb_if.load = load;
  assign sb_if.shift = xfer_act_ff && rise && !load; // R17
  assign sb_if.word = frame_b;

  dacr_frame_shift #(.W(dacr_pkg::DUAL_BITS)) u_shift_a (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sh(sa_if.unit)
  );

  dacr_frame_shift #(.W(dacr_pkg::FRAME_BITS)) u_shift_b (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sh(sb_if.unit)
  );

  // all outputs come from registers
  assign busy = busy_ff;
  assign sample_hold = hold_ff;
  assign serial_a = sa_if.ser_bit;
  assign serial_b = sb_if.ser_bit;
  assign serial_b_oe = b_oe_ff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_conv_start;
    state_ff == dacr_pkg::DACR_ARM && rise;
  endsequence

  sequence s_conv_done;
    state_ff == dacr_pkg::DACR_RUN && rise && conv_cnt_ff == 5'h14;
  endsequence

  a_busy_rise: assert property ( // R5
    state_ff == dacr_pkg::DACR_IDLE && stb_take && !ignore
      |=> busy_ff && hold_ff && state_ff == dacr_pkg::DACR_PEND)
    else $error("busy or hold not raised by strobe");

  a_conv_length: assert property ( // R4
    $fell(busy_ff) |-> $past(conv_cnt_ff) == 5'h14 && $past(rise))
    else $error("conversion did not last twenty cycles");

  a_busy_through: assert property ( // R5
    state_ff != dacr_pkg::DACR_IDLE |-> busy_ff && hold_ff)
    else $error("busy dropped early in conversion");

  a_start_edge: assert property ( // R15
    $rose(state_ff == dacr_pkg::DACR_RUN) |-> $past(rise) &&
      $past(state_ff) == dacr_pkg::DACR_ARM)
    else $error("conversion began off a rising edge");

  a_chan_latch: assert property ( // R6
    state_ff == dacr_pkg::DACR_RUN && fall && conv_cnt_ff == 5'h1
      |=> next_ch_ff == $past(a0_lvl))
    else $error("pair member not latched in cycle one");

  a_alternate: assert property ( // R12
    s_conv_start ##0 alt_lvl |=> cur_ch_ff != $past(cur_ch_ff))
    else $error("auto mode did not alternate pair member");

  a_mode1_flags: assert property ( // R9
    load && !alt_lvl && !dual_lvl |-> sa_if.word[39:38] == 2'h0 &&
      sb_if.word[19:18] == 2'h0)
    else $error("mode one flags not zero");

  a_frame_tail: assert property ( // R8
    load |-> sa_if.word[21:20] == 2'h0 && sb_if.word[1:0] == 2'h0 &&
      sa_if.word[37:22] == res_a_ff)
    else $error("frame layout wrong");

  a_b_float: assert property ( // R13
    s_conv_done ##0 dual_lvl |=> !serial_b_oe)
    else $error("output b still driven in dual mode");

  a_b_active: assert property ( // R12
    !dual_lvl |=> serial_b_oe)
    else $error("output b not driven in single mode");

  a_dual_ignore: assert property ( // R11
    stb_take && dual_lvl && xfer_act_ff && state_ff == dacr_pkg::DACR_IDLE
      |=> state_ff == dacr_pkg::DACR_IDLE && !$rose(busy_ff))
    else $error("strobe accepted during dual transfer");

  a_shift_after_rise: assert property ( // R17
    $changed(serial_a) |-> $past(rise))
    else $error("output a changed off a rising edge");
endmodule : dacr_top

// >>> bench/dacr_host_model.sv
// host-side model: free-running external clock, tied strobes, frame capture
module dacr_host_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic dual,
  input wire logic serial_a,
  input wire logic serial_b,
  output logic ext_clk,
  output logic strobe,
  output logic [39:0] cap_a,
  output logic [19:0] cap_b,
  output logic done
);
  timeunit 1ns;
  timeprecision 100ps;

  // 200 ns clock, slow enough for the three-stage pin synchronisers
  initial
  begin
    ext_clk = 1'b0;
    forever
    begin
      repeat (10) @(negedge ref_clk);
      ext_clk = ~ext_clk;
    end
  end

  // one request per go pulse; raised just after a rising edge, far from
  // the falling edge, so the start cycle is never in doubt
  initial
  begin
    strobe = 1'b0;
    done = 1'b0;
    cap_a = '0;
    cap_b = '0;
    forever
    begin
      @(posedge go);
      done = 1'b0;
      cap_a = '0;
      cap_b = '0;
      repeat (2) @(posedge ext_clk);
      @(negedge ref_clk);
      strobe = 1'b1;
      repeat (3) @(negedge ref_clk);
      strobe = 1'b0;
      repeat (3) @(posedge ext_clk);
      // bits are taken on falling edges, as a real host would
      for (int i = 0; i < (dual ? 40 : 20); i++)
      begin
        @(negedge ext_clk);
        cap_a = {cap_a[38:0], serial_a};
        cap_b = {cap_b[18:0], serial_b};
      end
      done = 1'b1;
    end
  end
endmodule : dacr_host_model

// >>> bench/dacr_top_test.sv
// self-checking bench for the dual converter readout control
module dacr_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, resetn, cs_n, cnt_sel, out_sel, mem_sel, go, tb_strobe;
  logic busy, sample_hold, serial_a, serial_b, serial_b_oe;
  logic ext_clk, p_strobe, done, ok, f;
  logic [15:0] res_a, res_b;
  logic [39:0] cap_a;
  logic [19:0] cap_b;
  int fails, cmp_count, busy_edges;

  dacr_top i_dacr_top (
    .ref_clk(ref_clk), .resetn(resetn), .ext_clk(ext_clk),
    .conversion_start_strobe(p_strobe | tb_strobe),
    .read_strobe(p_strobe | tb_strobe), .chip_select_n(cs_n),
    .channel_count_select(cnt_sel), .output_port_select(out_sel),
    .pair_member_select(mem_sel), .result_a_in(res_a), .result_b_in(res_b),
    .busy(busy), .sample_hold(sample_hold), .serial_a(serial_a),
    .serial_b(serial_b), .serial_b_oe(serial_b_oe)
  );

  dacr_host_model i_dacr_host_model (
    .ref_clk(ref_clk), .go(go), .dual(out_sel), .serial_a(serial_a),
    .serial_b(serial_b), .ext_clk(ext_clk), .strobe(p_strobe),
    .cap_a(cap_a), .cap_b(cap_b), .done(done)
  );

  // 100 MHz system clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // raw rising edges of the external clock while busy is up
  always @(posedge ext_clk) if (busy === 1'b1) busy_edges++;

  task automatic check(input logic good, input string what);
    cmp_count++;
    if (good !== 1'b1)
    begin
      fails++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check

  function automatic logic [19:0] frame(input logic fl, input logic sd,
                                        input logic [15:0] r);
    return {fl, sd, r, 2'h0};
  endfunction : frame

  // start one tied request and follow the conversion to its end
  task automatic conv(input logic [15:0] a, input logic [15:0] b);
    int n;
    @(negedge ref_clk);
    res_a = a;
    res_b = b;
    busy_edges = 0;
    go = 1'b1;
    @(negedge ref_clk);
    go = 1'b0;
    for (n = 0; busy !== 1'b1 && n < 100; n++) @(negedge ref_clk);
    check(busy === 1'b1 && sample_hold === 1'b1, "busy not raised");
    for (n = 0; busy === 1'b1 && n < 1000; n++) @(negedge ref_clk);
    // twenty cycles span 21 raw edges: busy drops only once the closing
    // edge has crossed the pin synchroniser
    check(busy === 1'b0 && busy_edges == 21, "conversion length");
  endtask : conv

  // wait, bounded, until the host has the whole frame
  task automatic fin();
    int n;
    for (n = 0; done !== 1'b1 && n < 2000; n++) @(negedge ref_clk);
    check(done === 1'b1, "frame capture stalled");
  endtask : fin

  // busy must stay low for the given span
  task automatic quiet(input int cyc, output logic good);
    good = 1'b1;
    repeat (cyc) @(negedge ref_clk) good &= (busy === 1'b0);
  endtask : quiet

  task automatic s_reset();
    check(busy === 1'b0 && sample_hold === 1'b0, "reset state");
    check(serial_b_oe === 1'b1, "b output enabled after reset");
  endtask : s_reset

  // pair member select high must still give zero flags
  task automatic s_mode_one();
    mem_sel = 1'b1;
    conv(16'ha5c3, 16'h3c5a);
    fin();
    conv(16'h0001, 16'hfffe);
    fin();
    check(cap_a[19:0] === frame(1'b0, 1'b0, 16'ha5c3),
          "frame a");
    check(cap_b === frame(1'b0, 1'b0, 16'h3c5a), "frame b");
    check(serial_b_oe === 1'b1, "b output dropped");
  endtask : s_mode_one

  task automatic s_cs_high();
    cs_n = 1'b1;
    @(negedge ref_clk);
    go = 1'b1;
    @(negedge ref_clk);
    go = 1'b0;
    quiet(100, ok);
    check(ok, "strobe with chip select high");
    fin();
    cs_n = 1'b0;
  endtask : s_cs_high

  // select line toggled to show that it is ignored
  task automatic s_mode_three();
    cnt_sel = 1'b1;
    conv(16'h8001, 16'h7ffe);
    fin();
    mem_sel = 1'b0;
    conv(16'h1234, 16'hedcb);
    fin();
    f = cap_a[19];
    check(f === 1'b0 || f === 1'b1, "alt flag unknown");
    check(cap_a[19:0] === frame(f, 1'b0, 16'h8001), "alt frame a");
    check(cap_b === frame(f, 1'b0, 16'h7ffe), "alt frame b");
    mem_sel = 1'b1;
    conv(16'h0000, 16'hffff);
    fin();
    check(cap_a[19:0] === frame(~f, 1'b0, 16'h1234), "no alternation");
  endtask : s_mode_three

  task automatic s_mode_four();
    out_sel = 1'b1;
    conv(16'hc001, 16'h3ffc);
    fin();
    check(serial_b_oe === 1'b0, "b still driven");
    conv(16'h5555, 16'haaaa);
    fin();
    f = cap_a[39];
    check(f === 1'b0 || f === 1'b1, "dual flag unknown");
    check(cap_a === {frame(f, 1'b0, 16'hc001), frame(f, 1'b1, 16'h3ffc)},
          "dual alt frame");
    conv(16'h0f0f, 16'hf0f0);
    fin();
    check(cap_a[39] === ~f, "dual no alternation");
  endtask : s_mode_four

  // second strobe lands while the forty-bit transfer runs
  task automatic s_mode_two();
    cnt_sel = 1'b0;
    conv(16'h9876, 16'h6789);
    fin();
    conv(16'hffff, 16'h0000);
    repeat (100) @(negedge ref_clk);
    tb_strobe = 1'b1;
    repeat (3) @(negedge ref_clk);
    tb_strobe = 1'b0;
    quiet(30, ok);
    check(ok, "strobe during dual transfer");
    fin();
    check(cap_a === {frame(1'b0, 1'b0, 16'h9876), frame(1'b0, 1'b1, 16'h6789)},
          "dual frame");
    check(serial_b_oe === 1'b0, "b still driven");
  endtask : s_mode_two

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // about a dozen requests of at most a thousand cycles each
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    $display("MISMATCH %0t watchdog expired", $time);
    conclude();
  end

  // main sequence
  initial
  begin
    resetn = 1'b0;
    cs_n = 1'b0;
    cnt_sel = 1'b0;
    out_sel = 1'b0;
    mem_sel = 1'b0;
    go = 1'b0;
    tb_strobe = 1'b0;
    res_a = '0;
    res_b = '0;
    fails = 0;
    cmp_count = 0;
    busy_edges = 0;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    s_reset();
    s_mode_one();
    s_cs_high();
    s_mode_three();
    s_mode_four();
    s_mode_two();
    conclude();
  end
endmodule : dacr_top_test
